// *** rtl/cvp_top.sv ***
// Purpose: cell overvoltage and undervoltage fault logic with apb configuration
// Assumes: cell voltages arrive as millivolt words synchronous to pclk
// Notes: all timing runs on a millisecond tick derived from pclk
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "cvp_map.svh"

module cvp_top #(
   parameter int unsigned TICK_CYCLES = `CVP_TICK_CYCLES // cycles per millisecond tick
) (
   input wire logic pclk,                      // apb clock, 100 mhz
   input wire logic presetn,                   // async reset, active low
   input wire logic psel,                      // apb select
   input wire logic penable,                   // apb access phase
   input wire logic pwrite,                    // apb direction
   input wire logic [7:0] paddr,               // apb byte address
   input wire logic [31:0] pwdata,             // apb write data
   output logic [31:0] prdata,                 // apb read data
   output logic pready,                        // apb ready
   output logic pslverr,                       // apb error
   input wire logic [12:0] cell_mv [10],       // cell voltages in mV, cell 0 first
   input wire logic charger_present,           // charger detected
   input wire logic load_present,              // load still attached
   output logic charge_switch,                 // charge fet on
   output logic discharge_switch,              // discharge fet on
   output logic temp_sense_line_out,           // temp sense drive level
   output logic temp_sense_line_oe,            // temp sense drive enable
   output logic shutdown_req,                  // shutdown request
   output logic irq                            // level interrupt
);

   cvp_pkg::cvp_state_t s;       // registered state
   cvp_pkg::cvp_state_t next_s;  // next state

   // overvoltage hysteresis table in mV
   function automatic logic [12:0] ov_hyst_mv(input logic [2:0] code);
      case (code)
         3'h0: ov_hyst_mv = 13'd300;
         3'h1: ov_hyst_mv = 13'd250;
         3'h2: ov_hyst_mv = 13'd200;
         3'h3: ov_hyst_mv = 13'd150;
         3'h4: ov_hyst_mv = 13'd100;
         3'h5: ov_hyst_mv = 13'd50;
         3'h6: ov_hyst_mv = 13'd25;
         default: ov_hyst_mv = 13'd0;
      endcase
   endfunction : ov_hyst_mv

   // register index of an aligned byte address
   function automatic logic [5:0] reg_index(input logic [7:0] addr);
      reg_index = addr[7:2];
   endfunction : reg_index

   // decoded configuration
   logic [3:0] cell_count;      // active series cells
   logic [12:0] ov_thr_mv;      // overvoltage trip level
   logic [12:0] ov_rel_mv;      // overvoltage release level
   logic [15:0] ov_dly_ms;      // overvoltage qualify time
   logic [12:0] uv_trip_mv;     // undervoltage trip level
   logic [12:0] uv_sum_mv;      // trip plus hysteresis, unclamped
   logic [12:0] undervoltage_recovery_mode_mv;      // undervoltage recovery level
   logic [15:0] uv_dly_ms;      // undervoltage qualify time
   logic [2:0] uv_dly_code;     // undervoltage delay code
   logic [9:0] cell_over;       // cell above ov trip
   logic [9:0] cell_ov_low;     // cell below ov release or unused
   logic [9:0] cell_under;      // cell below uv trip
   logic [9:0] cell_above_rec;  // cell above recovery or unused
   logic any_over;              // some cell over trip
   logic all_ov_low;            // all cells released
   logic any_under;             // some cell under trip
   logic all_above_rec;         // all cells recovered
   logic tick;                  // one millisecond elapsed
   logic apb_setup;             // setup phase of a transfer
   logic apb_wr;                // write takes effect now
   logic [5:0] idx;             // addressed register
   logic addr_ok;               // address maps to a register
   logic [4:0] events;          // events raised this cycle
   logic [4:0] int_clr;         // software clear of events
   logic [31:0] rd_word;        // read mux

   // configured cell count, code 7 is unusable so all ten are checked
   assign cell_count = (s.sys_cfg[`CVP_CNF_LSB +: 3] == 3'h7) ? 4'd10 :
                       4'd10 - {1'b0, s.sys_cfg[`CVP_CNF_LSB +: 3]};

   // overvoltage levels in mV
   assign ov_thr_mv = `CVP_OV_BASE_MV + 13'(s.ov_thr[5:0] * `CVP_OV_STEP_MV);
   assign ov_rel_mv = ov_thr_mv - ov_hyst_mv(s.ov_cfg[`CVP_OVH_LSB +: 3]);
   assign ov_dly_ms = `CVP_OV_DLY_BASE_MS + 16'(s.ov_cfg[2:0] * `CVP_OV_DLY_STEP_MS);

   // undervoltage levels in mV
   assign uv_trip_mv = `CVP_UV_BASE_MV + 13'(s.uv_thr[3:0] * `CVP_UV_STEP_MV);
   assign uv_sum_mv = uv_trip_mv + 13'({11'h0, s.uv_cfg[`CVP_UVH_LSB +: 2]} + 13'h1) * `CVP_UVH_STEP_MV;
   // clamp keeps recovery reachable for high trip codes
   always_comb begin
      if (s.uv_thr[`CVP_UV_INH_BIT]) begin
         undervoltage_recovery_mode_mv = uv_trip_mv;
      end else if (uv_sum_mv > `CVP_UNDERVOLTAGE_RECOVERY_MODE_MAX_MV) begin
         undervoltage_recovery_mode_mv = `CVP_UNDERVOLTAGE_RECOVERY_MODE_MAX_MV;
      end else begin
         undervoltage_recovery_mode_mv = uv_sum_mv;
      end
   end
   assign uv_dly_code = s.uv_cfg[2:0];
   assign uv_dly_ms = `CVP_UV_DLY_BASE_MS << uv_dly_code;

   // per cell comparisons, unused cells never trip and always release
   generate
      for (genvar i = 0; i < 10; i++) begin : g_cell
         logic used; // cell is in the configured stack
         assign used = 4'(i) < cell_count;
         assign cell_over[i] = used && (cell_mv[i] > ov_thr_mv);
         assign cell_ov_low[i] = !used || (cell_mv[i] < ov_rel_mv);
         assign cell_under[i] = used && (cell_mv[i] < uv_trip_mv);
         assign cell_above_rec[i] = !used || (cell_mv[i] > undervoltage_recovery_mode_mv);
      end
   endgenerate

   assign any_over = |cell_over;
   assign all_ov_low = &cell_ov_low;
   assign any_under = |cell_under;
   assign all_above_rec = &cell_above_rec;

   // apb decode
   assign tick = (s.tick_cnt >= TICK_CYCLES - 1);
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && s.pready && pwrite && !s.pslverr;
   assign idx = reg_index(paddr);
   always_comb begin
      case (idx)
         `CVP_IDX_SYS_CFG, `CVP_IDX_OV_THR, `CVP_IDX_OV_CFG, `CVP_IDX_UV_THR,
         `CVP_IDX_UV_CFG, `CVP_IDX_STATUS, `CVP_IDX_INT_STAT, `CVP_IDX_INT_EN,
         `CVP_IDX_INT_CLR: addr_ok = (paddr[1:0] == 2'h0);
         default: addr_ok = 1'b0;
      endcase
   end

   // read mux, clear register reads zero
   always_comb begin
      case (idx)
         `CVP_IDX_SYS_CFG: rd_word = {24'h0, s.sys_cfg};
         `CVP_IDX_OV_THR: rd_word = {24'h0, s.ov_thr};
         `CVP_IDX_OV_CFG: rd_word = {24'h0, s.ov_cfg};
         `CVP_IDX_UV_THR: rd_word = {24'h0, s.uv_thr};
         `CVP_IDX_UV_CFG: rd_word = {24'h0, s.uv_cfg};
         `CVP_IDX_STATUS: rd_word = {27'h0, s.shutdown_req, s.uv_state, s.ov_fault, s.irq};
         `CVP_IDX_INT_STAT: rd_word = {27'h0, s.int_stat};
         `CVP_IDX_INT_EN: rd_word = {27'h0, s.int_en};
         default: rd_word = 32'h0;
      endcase
   end
   assign int_clr = (apb_wr && idx == `CVP_IDX_INT_CLR) ? pwdata[4:0] : 5'h0;

   // next state
   always_comb begin
      next_s = s;
      events = 5'h0;
      // millisecond prescaler
      next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;

      // apb answers in the first access cycle, zero wait states
      next_s.pready = apb_setup;
      next_s.pslverr = apb_setup && !addr_ok;
      if (apb_setup) begin
         next_s.prdata = (addr_ok && !pwrite) ? rd_word : 32'h0;
      end
      if (apb_wr) begin
         case (idx)
            `CVP_IDX_SYS_CFG: next_s.sys_cfg = pwdata[7:0] & `CVP_MASK_SYS_CFG;
            `CVP_IDX_OV_THR: next_s.ov_thr = pwdata[7:0] & `CVP_MASK_OV_THR;
            `CVP_IDX_OV_CFG: next_s.ov_cfg = pwdata[7:0] & `CVP_MASK_OV_CFG;
            `CVP_IDX_UV_THR: next_s.uv_thr = pwdata[7:0] & `CVP_MASK_UV_THR;
            `CVP_IDX_UV_CFG: next_s.uv_cfg = pwdata[7:0] & `CVP_MASK_UV_CFG;
            `CVP_IDX_INT_EN: next_s.int_en = pwdata[4:0];
            default: ; // read-only and clear registers store nothing
         endcase
      end

      // overvoltage qualify timer restarts whenever the condition drops
      if (!s.ov_fault) begin
         if (!any_over) begin
            next_s.ov_timer = 16'h0;
         end else if (s.ov_timer >= ov_dly_ms) begin
            next_s.ov_fault = 1'b1;
            next_s.ov_timer = 16'h0;
            events[`CVP_EV_OV_TRIP] = 1'b1;
         end else if (tick) begin
            next_s.ov_timer = s.ov_timer + 16'h1;
         end
      end else if (all_ov_low) begin
         next_s.ov_fault = 1'b0;
         events[`CVP_EV_OV_CLEAR] = 1'b1;
      end

      // undervoltage supervisor
      case (s.uv_state)
         cvp_pkg::CVP_UV_OK: begin
            next_s.sd_timer = 16'h0;
            if (!any_under || uv_dly_code == `CVP_UV_DLY_OFF) begin
               next_s.uv_timer = 16'h0;
            end else if (s.uv_timer >= uv_dly_ms) begin
               next_s.uv_state = cvp_pkg::CVP_UV_FAULT;
               next_s.uv_timer = 16'h0;
               events[`CVP_EV_UV_TRIP] = 1'b1;
            end else if (tick) begin
               next_s.uv_timer = s.uv_timer + 16'h1;
            end
         end
         cvp_pkg::CVP_UV_FAULT: begin
            // recovery on voltage, mode 1 also waits for the load to go
            if (all_above_rec && (!s.uv_cfg[`CVP_UNDERVOLTAGE_RECOVERY_MODE_BIT] || !load_present)) begin
               next_s.uv_state = cvp_pkg::CVP_UV_OK;
               next_s.sd_timer = 16'h0;
               events[`CVP_EV_UV_RECOVER] = 1'b1;
            end else if (all_above_rec || !s.uv_cfg[`CVP_UV_SD_BIT]) begin
               next_s.sd_timer = 16'h0;
            end else if (s.sd_timer > `CVP_UV_SD_MS) begin
               next_s.uv_state = cvp_pkg::CVP_UV_SHDN;
               events[`CVP_EV_SHUTDOWN] = 1'b1;
            end else if (tick) begin
               next_s.sd_timer = s.sd_timer + 16'h1;
            end
         end
         cvp_pkg::CVP_UV_SHDN: begin
            next_s.uv_state = cvp_pkg::CVP_UV_SHDN; // only reset leaves shutdown
         end
         default: begin
            next_s.uv_state = cvp_pkg::CVP_UV_OK; // illegal code recovers
         end
      endcase

      // fet and line drive from the next fault state
      next_s.shutdown_req = (next_s.uv_state == cvp_pkg::CVP_UV_SHDN);
      next_s.discharge_switch = (next_s.uv_state == cvp_pkg::CVP_UV_OK);
      case (next_s.uv_state)
         cvp_pkg::CVP_UV_OK: next_s.charge_switch = !next_s.ov_fault;
         cvp_pkg::CVP_UV_FAULT: next_s.charge_switch = !next_s.ov_fault &&
                                   !s.uv_cfg[`CVP_UNDERVOLTAGE_RECOVERY_MODE_BIT] && charger_present;
         default: next_s.charge_switch = 1'b0;
      endcase
      next_s.ts_oe = next_s.ov_fault && s.ov_cfg[`CVP_PULLDOWN_BIT];

      // sticky events, a new event wins over a clear in the same cycle
      next_s.int_stat = (s.int_stat & ~int_clr) | events;
      next_s.irq = |(next_s.int_stat & next_s.int_en);
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.sys_cfg <= `CVP_RST_SYS_CFG;
         s.ov_thr <= `CVP_RST_OV_THR;
         s.ov_cfg <= `CVP_RST_OV_CFG;
         s.uv_thr <= `CVP_RST_UV_THR;
         s.uv_cfg <= `CVP_RST_UV_CFG;
         s.uv_state <= cvp_pkg::CVP_UV_OK;
         s.charge_switch <= 1'b1;
         s.discharge_switch <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register, except the temp sense level, which is tied low
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign charge_switch = s.charge_switch;
   assign discharge_switch = s.discharge_switch;
   assign temp_sense_line_out = 1'b0; // line is only ever pulled low
   assign temp_sense_line_oe = s.ts_oe;
   assign shutdown_req = s.shutdown_req;
   assign irq = s.irq;

endmodule : cvp_top

// *** rtl/cvp_map.svh ***
// Purpose: register offsets, field positions, reset values and timing counts for the cell voltage protector
// Assumes: apb byte address is four times the register index
// Notes: definitions only
`ifndef CVP_MAP_SVH
`define CVP_MAP_SVH

// register indices, byte address = 4 * index
`define CVP_IDX_SYS_CFG 6'h01
`define CVP_IDX_OV_THR 6'h02
`define CVP_IDX_OV_CFG 6'h03
`define CVP_IDX_UV_THR 6'h04
`define CVP_IDX_UV_CFG 6'h05
`define CVP_IDX_STATUS 6'h10
`define CVP_IDX_INT_STAT 6'h11
`define CVP_IDX_INT_EN 6'h12
`define CVP_IDX_INT_CLR 6'h13

// writable bit masks, reserved bits read zero
`define CVP_MASK_SYS_CFG 8'he0
`define CVP_MASK_OV_THR 8'h3f
`define CVP_MASK_OV_CFG 8'hf7
`define CVP_MASK_UV_THR 8'h8f
`define CVP_MASK_UV_CFG 8'hf7

// reset values
`define CVP_RST_SYS_CFG 8'h00
`define CVP_RST_OV_THR 8'h38
`define CVP_RST_OV_CFG 8'h00
`define CVP_RST_UV_THR 8'h00
`define CVP_RST_UV_CFG 8'h00

// field positions
`define CVP_CNF_LSB 5
`define CVP_PULLDOWN_BIT 7
`define CVP_OVH_LSB 4
`define CVP_UV_INH_BIT 7
`define CVP_UNDERVOLTAGE_RECOVERY_MODE_BIT 7
`define CVP_UV_SD_BIT 6
`define CVP_UVH_LSB 4

// interrupt event bits
`define CVP_EV_OV_TRIP 0
`define CVP_EV_OV_CLEAR 1
`define CVP_EV_UV_TRIP 2
`define CVP_EV_UV_RECOVER 3
`define CVP_EV_SHUTDOWN 4

// voltage scale in millivolts
`define CVP_OV_BASE_MV 13'd2800
`define CVP_OV_STEP_MV 13'd25
`define CVP_UV_BASE_MV 13'd1400
`define CVP_UV_STEP_MV 13'd100
`define CVP_UVH_STEP_MV 13'd400
`define CVP_UNDERVOLTAGE_RECOVERY_MODE_MAX_MV 13'd3500

// timing: one millisecond timebase
`define CVP_CLK_NS 10
`define CVP_TICK_NS 1000000
`define CVP_TICK_CYCLES (`CVP_TICK_NS / `CVP_CLK_NS)
`define CVP_OV_DLY_BASE_MS 16'd500
`define CVP_OV_DLY_STEP_MS 16'd250
`define CVP_UV_DLY_BASE_MS 16'd500
`define CVP_UV_SD_MS 16'd8000
`define CVP_UV_DLY_OFF 3'h7

`endif

// *** rtl/cvp_pkg.sv ***
// Purpose: types of the cell voltage protector
// Assumes: nothing beyond the map header
// Notes: state of the top module is one packed struct
package cvp_pkg;

   // undervoltage supervisor states
   typedef enum logic [1:0] {
      CVP_UV_OK = 2'b00,    // normal operation
      CVP_UV_FAULT = 2'b01, // undervoltage fault held
      CVP_UV_SHDN = 2'b10   // shutdown requested, left only by reset
   } cvp_uv_state_t;

   // whole state of the protector
   typedef struct packed {
      logic [7:0] sys_cfg;        // cell count field
      logic [7:0] ov_thr;         // overvoltage trip code
      logic [7:0] ov_cfg;         // pulldown, hysteresis, delay
      logic [7:0] uv_thr;         // inhibit, trip code
      logic [7:0] uv_cfg;         // recovery, shutdown, hysteresis, delay
      logic [4:0] int_stat;       // sticky events
      logic [4:0] int_en;         // event enables
      cvp_uv_state_t uv_state;    // undervoltage state
      logic ov_fault;             // overvoltage fault held
      logic [31:0] tick_cnt;      // millisecond prescaler
      logic [15:0] ov_timer;      // overvoltage qualify time, ms
      logic [15:0] uv_timer;      // undervoltage qualify time, ms
      logic [15:0] sd_timer;      // shutdown qualify time, ms
      logic charge_switch;        // charge fet enable
      logic discharge_switch;     // discharge fet enable
      logic ts_oe;                // temp sense pulldown active
      logic shutdown_req;         // shutdown request
      logic irq;                  // interrupt line
      logic [31:0] prdata;        // apb read data
      logic pready;               // apb ready
      logic pslverr;              // apb error
   } cvp_state_t;

endpackage : cvp_pkg

// *** dv/cvp_checker_assertions.sv ***
// Purpose: port-level checks of the cell voltage protector
// Assumes: pulldown and shutdown enables are mirrored from apb writes seen at the ports
// Notes: bound to cvp_top below
`timescale 1ns/1ps

module cvp_checker (
   input wire logic pclk,               // apb clock
   input wire logic presetn,            // async reset, active low
   input wire logic psel,               // apb select
   input wire logic penable,            // apb access phase
   input wire logic pwrite,             // apb direction
   input wire logic [7:0] paddr,        // apb byte address
   input wire logic [31:0] pwdata,      // apb write data
   input wire logic pready,             // apb ready
   input wire logic pslverr,            // apb error
   input wire logic charge_switch,      // charge fet on
   input wire logic discharge_switch,   // discharge fet on
   input wire logic temp_sense_line_out, // temp sense drive level
   input wire logic temp_sense_line_oe, // temp sense drive enable
   input wire logic shutdown_req        // shutdown request
);
   logic pd_q; // mirrored pulldown enable
   logic sd_q; // mirrored shutdown enable

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // mirror the enables only on completed writes, a setup alone changes nothing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_q <= 1'b0;
         sd_q <= 1'b0;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == 8'h0c) pd_q <= pwdata[7];
         if (paddr == 8'h14) sd_q <= pwdata[6];
      end
   end

   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready in first access cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_pulldown_gated: assert property ($rose(temp_sense_line_oe) |-> pd_q)
      else $error("pulldown while not enabled");
   a_line_driven_low: assert property (temp_sense_line_oe |-> !temp_sense_line_out)
      else $error("temp sense driven high");
   a_pulldown_no_charge: assert property (temp_sense_line_oe |-> !charge_switch)
      else $error("pulldown while charging");
   a_shutdown_gated: assert property ($rose(shutdown_req) |-> sd_q)
      else $error("shutdown while disabled");
   a_shutdown_sticky: assert property (shutdown_req |=> shutdown_req)
      else $error("shutdown left without reset");
   a_shutdown_fets_off: assert property (shutdown_req |=> !charge_switch && !discharge_switch)
      else $error("fet on in shutdown");
   a_reset_fets_on: assert property ($rose(presetn) |-> charge_switch && discharge_switch)
      else $error("fets off after reset");
endmodule : cvp_checker

bind cvp_top cvp_checker cvp_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .pslverr, .charge_switch, .discharge_switch, .temp_sense_line_out, .temp_sense_line_oe,
   .shutdown_req);

// *** dv/cvp_cells.sv ***
// Purpose: behavioural pack of cells, charger and load
// Assumes: the bench sets levels just after a clock edge
// Notes: all cells sit at one level except one chosen cell
`timescale 1ns/1ps

module cvp_cells (
   input wire logic [12:0] nom_mv,  // level of every other cell, mV
   input wire logic [3:0] hit_idx,  // cell given its own level
   input wire logic [12:0] hit_mv,  // level of that cell, mV
   input wire logic chg_in,         // charger attached
   input wire logic load_in,        // load attached
   output logic [12:0] cell_mv [10], // cell voltages, cell 0 first
   output logic charger_present,    // charger sense
   output logic load_present        // load sense
);
   // one odd cell is enough to reach every trip and recovery boundary
   always_comb begin
      for (int n = 0; n < 10; n++) cell_mv[n] = (n == hit_idx) ? hit_mv : nom_mv;
      charger_present = chg_in;
      load_present = load_in;
   end
endmodule : cvp_cells

// *** dv/cell_ov_uv_protection_config_bench.sv ***
// Purpose: self-checking bench of the cell voltage protector
// Assumes: zero-wait apb, millisecond tick shortened to TICK cycles
// Notes: random levels and codes from a fixed seed, boundaries written by hand
`timescale 1ns/1ps
`include "cvp_map.svh"

module cell_ov_uv_protection_config_bench;
   localparam int TICK = 2; // cycles per ms tick, short for run time
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [12:0] cell_mv [10];
   logic [12:0] nom_mv, hit_mv;
   logic [3:0] hit_idx, undervoltage_threshold_sel;
   logic [1:0] undervoltage_hysteresis_sel;
   logic chg, load, charger_present, load_present, charge_switch, discharge_switch, ts_out, ts_oe;
   logic shutdown_req, irq, pd;
   int miscompares, tests_run, seed, i, d, h, trip, rec, k;

   cvp_top #(.TICK_CYCLES(TICK)) cvp_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .cell_mv, .charger_present, .load_present, .charge_switch,
      .discharge_switch, .temp_sense_line_out(ts_out), .temp_sense_line_oe(ts_oe), .shutdown_req, .irq);
   cvp_cells cvp_cells_inst (.nom_mv, .hit_idx, .hit_mv, .chg_in(chg), .load_in(load), .cell_mv,
      .charger_present, .load_present);

   // 100 mhz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer, held until ready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 20);
      chk(pready, 1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // wait whole milliseconds
   task automatic tk(input int n);
      repeat (n * TICK) @(posedge pclk);
   endtask : tk

   task automatic rst;
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
   endtask : rst

   // overvoltage hysteresis in mV for a code
   function automatic int overvoltage_hysteresis_sel(input int c);
      return (c < 6) ? 300 - 50 * c : (c == 6 ? 25 : 0);
   endfunction : overvoltage_hysteresis_sel

   // undervoltage recovery level, clamped only when hysteresis is used
   function automatic int undervoltage_recovery_mode(input int t, input int c, input logic inh);
      if (inh) return t;
      return (t + 400 * (c + 1) > 3500) ? 3500 : t + 400 * (c + 1);
   endfunction : undervoltage_recovery_mode

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // watchdog sized above the roughly 70k cycles the tests need
   initial begin
      #950000;
      miscompares++;
      give_verdict();
   end

   initial begin
      seed = 32'h5830;
      {psel, penable, pwrite, paddr, pwdata, chg, load, hit_idx} = '0;
      presetn = 1'b0;
      nom_mv = 13'd3700;
      hit_mv = 13'd3700;
      rst();
      // reset values and writable bits of the ov_cfg, uv_thr and uv_cfg registers
      for (i = 0; i < 3; i++) begin
         apb(0, 8'(8'h0c + 4 * i), 0);
         chk(rd, 0);
         k = $random(seed);
         apb(1, 8'(8'h0c + 4 * i), k);
         apb(0, 8'(8'h0c + 4 * i), 0);
         chk(rd, k & (i == 0 ? `CVP_MASK_OV_CFG : (i == 1 ? `CVP_MASK_UV_THR : `CVP_MASK_UV_CFG)));
      end
      apb(0, 8'h08, 0);
      chk(rd, 32'h38);
      apb(0, 8'h20, 0);
      chk(err, 1);
      $display("test registers done");
      // four cells: a fifth cell over the limit is ignored
      apb(1, 8'h04, 32'hc0);
      apb(1, 8'h10, 0);
      apb(1, 8'h14, 32'h07);
      apb(1, 8'h0c, 32'h80);
      hit_idx <= 4'd4;
      hit_mv <= 13'd4300;
      tk(510);
      chk(charge_switch, 1);
      // every overvoltage delay and hysteresis code, with a timer restart
      for (i = 0; i < 8; i++) begin
         pd = ~i[0];
         k = $unsigned($random(seed)) % 4;
         apb(1, 8'h0c, {24'h0, pd, 3'(i), 1'b0, 3'(i)});
         d = 500 + 250 * i;
         h = overvoltage_hysteresis_sel(i);
         hit_idx <= 4'(k);
         hit_mv <= 13'd4201;
         tk(d / 2);
         hit_mv <= 13'd4200;
         tk(2);
         hit_mv <= 13'd4201;
         tk(d - 5);
         chk(charge_switch, 1);
         tk(10);
         chk(charge_switch, 0);
         chk(ts_oe, pd);
         if (i == 0) begin
            apb(0, 8'h44, 0);
            chk(rd[0], 1);
            apb(1, 8'h48, 1);
            tk(2);
            chk(irq, 1);
            apb(1, 8'h48, 0);
            tk(2);
            chk(irq, 0);
            apb(1, 8'h4c, 32'h1f);
            apb(0, 8'h44, 0);
            chk(rd[0], 0);
         end
         hit_mv <= 13'(4200 - h);
         tk(5);
         chk(charge_switch, 0);
         hit_mv <= 13'(4199 - h);
         tk(5);
         chk(charge_switch, 1);
         chk(ts_oe, 0);
      end
      // random trip code: at the level no trip, one mV above it trips
      k = $unsigned($random(seed)) % 64;
      h = 2800 + 25 * k;
      apb(1, 8'h0c, 0);
      apb(1, 8'h08, k);
      nom_mv <= 13'(h - 400);
      hit_mv <= 13'(h);
      tk(510);
      chk(charge_switch, 1);
      hit_mv <= 13'(h + 1);
      tk(510);
      chk(charge_switch, 0);
      hit_mv <= 13'(h - 400);
      tk(5);
      chk(charge_switch, 1);
      apb(1, 8'h08, 32'h38);
      nom_mv <= 13'd3700;
      hit_mv <= 13'd3700;
      $display("test overvoltage done");
      // undervoltage delay codes, recovery modes, inhibit and clamp
      for (i = 0; i < 4; i++) begin
         undervoltage_threshold_sel = (i == 1) ? 4'hf : 4'($random(seed));
         undervoltage_hysteresis_sel = (i == 1) ? 2'h3 : 2'($random(seed));
         trip = 1400 + 100 * undervoltage_threshold_sel;
         rec = undervoltage_recovery_mode(trip, undervoltage_hysteresis_sel, i[1]);
         d = 500 << i;
         chg <= 1'($random(seed));
         load <= 1'b1;
         apb(1, 8'h10, {24'h0, i[1], 3'h0, undervoltage_threshold_sel});
         apb(1, 8'h14, {24'h0, i[0], 1'b0, undervoltage_hysteresis_sel, 1'b0, 3'(i)});
         hit_idx <= 4'd0;
         hit_mv <= 13'(trip - 1);
         tk(d - 5);
         chk(discharge_switch, 1);
         tk(10);
         chk(discharge_switch, 0);
         chk(charge_switch, !i[0] && chg);
         hit_mv <= 13'(rec);
         tk(5);
         chk(discharge_switch, 0);
         hit_mv <= 13'(rec + 1);
         tk(5);
         chk(discharge_switch, !i[0]);
         load <= 1'b0;
         tk(5);
         chk(discharge_switch, 1);
      end
      $display("test undervoltage done");
      // delay code 7 never trips
      apb(1, 8'h14, 32'h07);
      hit_mv <= 13'd1300;
      tk(600);
      chk(discharge_switch, 1);
      // shutdown after 8 s in the fault
      apb(1, 8'h14, 32'h40);
      tk(510);
      chk(discharge_switch, 0);
      tk(7980);
      chk(shutdown_req, 0);
      tk(30);
      chk(shutdown_req, 1);
      chk(charge_switch, 0);
      hit_mv <= 13'd3700;
      rst();
      chk(shutdown_req, 0);
      chk(charge_switch, 1);
      apb(0, 8'h14, 0);
      chk(rd, 0);
      $display("test shutdown done");
      give_verdict();
   end
endmodule : cell_ov_uv_protection_config_bench
